// *** verification/host_model.sv ***
// host side model that drives the switch enable
`timescale 1ns/1ps
module host_model
(
   input  wire logic en_req,
   output logic      load_switch_enable
);
   // the enable request is passed straight through, with no hold time added
   assign load_switch_enable = en_req;
endmodule

// *** verification/load_switch_ctrl_diag_tb_top.sv ***
// self-checking bench for the load switch control block
`timescale 1ns/1ps
module load_switch_ctrl_diag_tb_top;
   import load_switch_pkg::*;
   // stim bits: supply, enable, overcurrent, underload, hot, released
   logic       ref_clk = 1'b0;
   logic       rst_n = 1'b0;
   logic [5:0] stim = 6'h20;
   logic [2:0] r;
   logic       host_en;
   logic       load_switch_out;
   logic       load_fault_n;
   int         errors = 0;
   int         checks_done = 0;

   always #50 ref_clk = ~ref_clk;

   host_model host_model_inst (.en_req(stim[4]), .load_switch_enable(host_en));

   load_switch_ctrl_diag #(.OC_DELAY(2), .ULD_DELAY(2))
      load_switch_ctrl_diag_inst (.ref_clk(ref_clk), .rst_n(rst_n),
      .supply_ok(stim[5]), .load_switch_enable(host_en),
      .over_current(stim[3]), .under_load(stim[2]), .over_temp(stim[1]),
      .temp_released(stim[0]), .load_switch_out(load_switch_out),
      .load_fault_n(load_fault_n));

   // settled switch and fault pin for steady inputs
   function automatic logic [1:0] steady(input logic [5:0] s);
      logic on;
      on = s[5] & s[4];
      return {on & ~s[3] & ~s[1], ~(on & (s[3] | s[2] | s[1]))};
   endfunction

   task automatic check(input logic [1:0] seen, input logic [1:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic run(input logic [5:0] s, input int n,
                      input logic [1:0] exp);
      stim = s;
      repeat (n) @(negedge ref_clk);
      check({load_switch_out, load_fault_n}, exp);
   endtask

   task automatic stop_test;
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   initial
   begin
      #200000;
      errors++;
      stop_test;
   end

   initial
   begin
      void'($urandom(22));
      repeat (20) @(negedge ref_clk);
      rst_n = 1'b1;
      run(6'h31, 3, 2'b11);
      run(6'h21, 3, 2'b01);
      run(6'h2e, 8, 2'b01);
      run(6'h31, 2, 2'b11);
      run(6'h39, 1, 2'b11);
      run(6'h31, 3, 2'b11);
      run(6'h39, 8, 2'b00);
      run(6'h31, 4, 2'b00);
      run(6'h21, 3, 2'b01);
      run(6'h31, 3, 2'b11);
      run(6'h35, 8, 2'b10);
      run(6'h31, 4, 2'b11);
      run(6'h36, 8, 2'b00);
      run(6'h34, 4, 2'b00);
      run(6'h37, 3, 2'b00);
      run(6'h35, 8, 2'b10);
      run(6'h31, 4, 2'b11);
      run(6'h11, 3, 2'b01);
      run(6'h31, 3, 2'b11);
      run(6'h39, 8, 2'b00);
      rst_n = 1'b0;
      run(6'h39, 2, 2'b01);
      rst_n = 1'b1;
      run(6'h39, 2, 2'b11);
      run(6'h39, 2, 2'b00);
      repeat (20)
      begin
         r = 3'($urandom);
         run(6'h21, 2, 2'b01);
         run({2'b11, r, ~r[0]}, 8, steady({2'b11, r, ~r[0]}));
      end
      stop_test;
   end
endmodule

// *** verilog/fault_filter.sv ***
// debounce filter: output rises after a condition holds for N cycles
`timescale 1ns/1ps
module fault_filter
   import load_switch_pkg::*;
#(
   parameter int DELAY_CYC = 10
)(
   input  wire logic ref_clk,
   input  wire logic rst_n,
   input  wire logic clear,
   input  wire logic cond,
   output logic      hit
);
   logic [FILT_W-1:0] cnt_q;
   logic [FILT_W-1:0] cnt_d;
   logic              hit_q;
   logic              hit_d;

   always_comb
   begin
      cnt_d = cnt_q;
      hit_d = 1'b0;
      if (clear || !cond)
      begin
         cnt_d = '0;
      end
      else if (cnt_q >= FILT_W'(DELAY_CYC - 1))
      begin
         hit_d = 1'b1;
      end
      else
      begin
         cnt_d = cnt_q + FILT_W'(1);
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         cnt_q <= '0;
         hit_q <= 1'b0;
      end
      else
      begin
         cnt_q <= cnt_d;
         hit_q <= hit_d;
      end
   end

   assign hit = hit_q;
endmodule

// *** verilog/load_switch_ctrl_diag.sv ***
// load switch control with overcurrent, underload and thermal diagnostics
`timescale 1ns/1ps
module load_switch_ctrl_diag
   import load_switch_pkg::*;
#(
   parameter int OC_DELAY  = OC_FILTER_CYC,
   parameter int ULD_DELAY = ULD_FILTER_CYC
)(
   input  wire logic ref_clk,
   input  wire logic rst_n,
   input  wire logic supply_ok,
   input  wire logic load_switch_enable,
   input  wire logic over_current,
   input  wire logic under_load,
   input  wire logic over_temp,
   input  wire logic temp_released,
   output logic      load_switch_out,
   output logic      load_fault_n
);
   // ----------------------------------------
   // fault state
   // ----------------------------------------
   logic oc_q;
   logic oc_d;
   logic ot_q;
   logic ot_d;
   logic sw_q;
   logic sw_d;
   logic fault_n_q;
   logic fault_n_d;
   logic oc_hit;
   logic uld_hit;
   logic powered;
   logic en;

   assign powered = rst_n && supply_ok;
   assign en      = load_switch_enable;

   fault_filter #(
      .DELAY_CYC (OC_DELAY)
   ) u_oc_filt (
      .ref_clk (ref_clk),
      .rst_n   (powered),
      .clear   (!en),
      .cond    (over_current),
      .hit     (oc_hit)
   );

   fault_filter #(
      .DELAY_CYC (ULD_DELAY)
   ) u_uld_filt (
      .ref_clk (ref_clk),
      .rst_n   (powered),
      .clear   (!en || !sw_q),
      .cond    (under_load),
      .hit     (uld_hit)
   );

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb
   begin
      oc_d = oc_q;
      ot_d = ot_q;
      if (!en)
      begin
         oc_d = 1'b0;
         ot_d = 1'b0;
      end
      else
      begin
         if (oc_hit)
         begin
            oc_d = 1'b1;
         end
         if (over_temp)
         begin
            ot_d = 1'b1;
         end
         else if (temp_released)
         begin
            ot_d = 1'b0;
         end
      end
      // switch follows enable unless a shut-off fault is present
      sw_d = en && !oc_d && !ot_d;
      // underload leaves switch on, only flags
      fault_n_d = !(oc_d || ot_d || (en && uld_hit));
   end

   always_ff @(posedge ref_clk)
   begin
      if (!powered)
      begin
         oc_q      <= RST_LATCH;
         ot_q      <= RST_LATCH;
         sw_q      <= RST_SWITCH;
         fault_n_q <= RST_FAULT_N;
      end
      else
      begin
         oc_q      <= oc_d;
         ot_q      <= ot_d;
         sw_q      <= sw_d;
         fault_n_q <= fault_n_d;
      end
   end

   assign load_switch_out = sw_q;
   assign load_fault_n    = fault_n_q;

   // ----------------------------------------
   // filter run counters for checks
   // ----------------------------------------
   logic [FILT_W-1:0] oc_run_q;
   logic [FILT_W-1:0] oc_run_d;
   logic [FILT_W-1:0] uld_run_q;
   logic [FILT_W-1:0] uld_run_d;
   logic              oc_run_full;
   logic              uld_run_full;

   assign oc_run_full  = oc_run_q >= FILT_W'(OC_DELAY);
   assign uld_run_full = uld_run_q >= FILT_W'(ULD_DELAY);

   always_comb
   begin
      oc_run_d  = '0;
      uld_run_d = '0;
      if (en && over_current)
      begin
         oc_run_d = oc_run_full ? oc_run_q : oc_run_q + FILT_W'(1);
      end
      if (en && sw_q && under_load)
      begin
         uld_run_d = uld_run_full ? uld_run_q : uld_run_q + FILT_W'(1);
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!powered)
      begin
         oc_run_q  <= '0;
         uld_run_q <= '0;
      end
      else
      begin
         oc_run_q  <= oc_run_d;
         uld_run_q <= uld_run_d;
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!powered);

   sequence run_clear;
      en && !oc_q && !oc_hit && !over_temp && (temp_released || !ot_q);
   endsequence

   a_switch_follows: assert property (
      run_clear |=> load_switch_out)
      else $error("switch not on while enabled");
   a_switch_off_dis: assert property (
      !en |=> !load_switch_out && load_fault_n)
      else $error("switch or fault active while disabled");
   a_checks_enabled: assert property (
      !en |=> !oc_q && !ot_q)
      else $error("fault held while disabled");

   sequence oc_trip;
      en && oc_hit;
   endsequence
   a_oc_latch: assert property (
      oc_trip ##1 en |=> !load_switch_out && !load_fault_n)
      else $error("overcurrent not latched");
   a_uld_flag: assert property (
      run_clear ##0 uld_hit |=> load_switch_out && !load_fault_n)
      else $error("underload flag wrong");
   a_ot_off: assert property (
      (en && over_temp) |=> !load_switch_out && !load_fault_n)
      else $error("thermal shutdown missing");
   a_oc_filter: assert property (
      (en && !over_current) ##1 (en && over_current) |-> !oc_hit)
      else $error("overcurrent filter too short");

   a_oc_filter_len: assert property (
      oc_hit == oc_run_full)
      else $error("overcurrent filter length wrong");

   a_uld_filter_len: assert property (
      uld_hit == uld_run_full)
      else $error("underload filter length wrong");
   a_fault_or: assert property (
      (oc_q || ot_q) |-> !load_fault_n)
      else $error("fault pin released early");
   a_por_hold: assert property (
      @(posedge ref_clk) disable iff (1'b0)
      !supply_ok |=> !load_switch_out && load_fault_n)
      else $error("switch or fault active below por level");

   a_rst_hold: assert property (
      @(posedge ref_clk) disable iff (1'b0)
      !rst_n |=> !load_switch_out && load_fault_n)
      else $error("switch or fault active in reset");

   sequence ot_held;
      en && ot_q && !over_temp && !temp_released;
   endsequence
   sequence ot_freed;
      en && ot_q && !over_temp && temp_released && !oc_q && !oc_hit;
   endsequence

   a_ot_hyst: assert property (
      ot_held |=> !load_switch_out && !load_fault_n)
      else $error("thermal fault released inside hysteresis");

   a_ot_recover: assert property (
      ot_freed |=> load_switch_out)
      else $error("switch not back after thermal release");

   a_oc_hold: assert property (
      (en && oc_q) |=> !load_switch_out && !load_fault_n)
      else $error("overcurrent latch lost while enabled");

   a_fault_release: assert property (
      run_clear ##0 !uld_hit |=> load_switch_out && load_fault_n)
      else $error("fault pin low with no fault");
endmodule

// *** verilog/load_switch_pkg.sv ***
// constants for the load switch control and diagnostic block
// Behaviour
// - the switch output follows enable, and with no fault the fault pin stays high.
// - current and temperature checks run only while enable is high.
// - overcurrent turns the switch off and latches a fault until enable goes low.
// - underload keeps the switch on and flags a fault until current recovers.
// - over-temperature turns the switch off until temperature falls below release.
// - below the supply power-on-reset level everything is held powered down.
package load_switch_pkg;
   // filter delays in ns at the 10 MHz clock
   localparam int CLK_PERIOD_NS            = 100;
   localparam int OC_FILTER_NS             = 1000;
   localparam int ULD_FILTER_NS            = 1000;
   localparam int OC_FILTER_CYC            =
      (OC_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ULD_FILTER_CYC           =
      (ULD_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int FILT_W                   = 8;
   localparam logic RST_SWITCH             = 1'b0;
   localparam logic RST_LATCH              = 1'b0;
   localparam logic RST_FAULT_N            = 1'b1;
endpackage
